// ===== logic/bkrl_consts.svh
// Purpose: Constants of the breakpoint register logic
// Assumes: 8-bit register port, 3-bit register address
// Notes: Summary of operation follows
`ifndef BKRL_CONSTS_SVH
`define BKRL_CONSTS_SVH
// Register offsets
`define BKRL_OFS_SC 3'h0
`define BKRL_OFS_AH 3'h1
`define BKRL_OFS_AL 3'h2
`define BKRL_OFS_WS 3'h3
`define BKRL_OFS_FC 3'h4
`define BKRL_OFS_IST 3'h5
`define BKRL_OFS_ICLR 3'h6
`define BKRL_OFS_IEN 3'h7
// Field positions
`define BKRL_BIT_EN 7
`define BKRL_BIT_ACT 6
`define BKRL_BIT_WAKE 1
`define BKRL_BIT_CFE 7
`define BKRL_IRQ_MATCH 0
`define BKRL_IRQ_SOFT 1
`define BKRL_IRQ_WAKE 2
// Reset values
`define BKRL_RST_BYTE 8'h00
`define BKRL_RST_IRQ 3'h0
`endif

// ===== logic/bkrl_pkg.sv
// Purpose: Types of the breakpoint register logic
// Assumes: Used with bkrl_consts.svh
// Notes: All module state is one packed struct
package bkrl_pkg;
  // Match sequencing states, Gray coded
  typedef enum logic [1:0]
  {
    BKRL_ST_IDLE = 2'b00,
    BKRL_ST_PEND = 2'b01
  } bkrl_state_t;

  // Whole module state
  typedef struct packed
  {
    logic en;
    logic act;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic wake;
    logic cfe;
    logic [2:0] ist;
    logic [2:0] ien;
    bkrl_state_t st;
    logic brk;
    logic irq;
    logic [7:0] rdata;
  } bkrl_regs_t;
endpackage

// ===== logic/bkrl_top.sv
// Purpose: Breakpoint compare, break request and status registers
// Assumes: CPU signals share the clock; single-cycle strobes
// Notes: Break request and interrupt come straight from flops
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bkrl_consts.svh"

module bkrl_top
(
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CPU side
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_addr_valid,
  input wire logic cpu_instr_last,
  input wire logic cpu_in_break,
  input wire logic cpu_low_power,
  output logic break_req,
  // Interrupt
  output logic irq
);

  // Register copy and next value
  bkrl_pkg::bkrl_regs_t r_q;
  bkrl_pkg::bkrl_regs_t r_d;

  // Address decode helper
  function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
    hit = (a == o);
  endfunction

  // Combinational helpers
  logic match;
  logic sw_trig;
  logic fire_match;
  logic fire;
  logic clr_ok;
  logic [2:0] ev;

  // Next-state logic
  always_comb
  begin
    r_d = r_q;
    // Full 16-bit compare against both bytes
    match = r_q.en && cpu_addr_valid
      && (cpu_addr == {r_q.addr_hi, r_q.addr_lo});
    // Status clears blocked in break state unless allowed
    clr_ok = !cpu_in_break || r_q.cfe;
    sw_trig = reg_wr && hit(reg_addr, `BKRL_OFS_SC)
      && reg_wdata[`BKRL_BIT_ACT];
    fire_match = 1'b0;
    // Match sequencing to instruction boundary
    case (r_q.st)
      bkrl_pkg::BKRL_ST_IDLE:
      begin
        if (match && cpu_instr_last)
        begin
          fire_match = 1'b1;
        end
        else if (match)
        begin
          r_d.st = bkrl_pkg::BKRL_ST_PEND;
        end
      end
      bkrl_pkg::BKRL_ST_PEND:
      begin
        if (cpu_instr_last)
        begin
          fire_match = 1'b1;
          r_d.st = bkrl_pkg::BKRL_ST_IDLE;
        end
      end
      default:
      begin
        r_d.st = bkrl_pkg::BKRL_ST_IDLE;
      end
    endcase
    fire = fire_match || sw_trig;
    // One pulse per trigger
    r_d.brk = fire;
    // Register writes
    if (reg_wr)
    begin
      if (hit(reg_addr, `BKRL_OFS_SC))
      begin
        r_d.en = reg_wdata[`BKRL_BIT_EN];
        if (!reg_wdata[`BKRL_BIT_ACT] && clr_ok)
        begin
          r_d.act = 1'b0;
        end
      end
      else if (hit(reg_addr, `BKRL_OFS_AH))
      begin
        r_d.addr_hi = reg_wdata;
      end
      else if (hit(reg_addr, `BKRL_OFS_AL))
      begin
        r_d.addr_lo = reg_wdata;
      end
      else if (hit(reg_addr, `BKRL_OFS_WS))
      begin
        if (!reg_wdata[`BKRL_BIT_WAKE] && clr_ok)
        begin
          r_d.wake = 1'b0;
        end
      end
      else if (hit(reg_addr, `BKRL_OFS_FC))
      begin
        r_d.cfe = reg_wdata[`BKRL_BIT_CFE];
      end
      else if (hit(reg_addr, `BKRL_OFS_ICLR))
      begin
        if (clr_ok)
        begin
          r_d.ist = r_q.ist & ~reg_wdata[2:0];
        end
      end
      else if (hit(reg_addr, `BKRL_OFS_IEN))
      begin
        r_d.ien = reg_wdata[2:0];
      end
    end
    // Hardware sets win over software clears
    if (match || sw_trig)
    begin
      r_d.act = 1'b1;
    end
    if (fire && cpu_low_power)
    begin
      r_d.wake = 1'b1;
    end
    ev = 3'h0;
    ev[`BKRL_IRQ_MATCH] = fire_match;
    ev[`BKRL_IRQ_SOFT] = sw_trig;
    ev[`BKRL_IRQ_WAKE] = fire && cpu_low_power;
    r_d.ist = r_d.ist | ev;
    r_d.irq = |(r_d.ist & r_d.ien);
    // Read data, one cycle after the strobe
    r_d.rdata = 8'h00;
    if (reg_rd)
    begin
      if (hit(reg_addr, `BKRL_OFS_SC))
      begin
        r_d.rdata[`BKRL_BIT_EN] = r_q.en;
        r_d.rdata[`BKRL_BIT_ACT] = r_q.act;
      end
      else if (hit(reg_addr, `BKRL_OFS_AH))
      begin
        r_d.rdata = r_q.addr_hi;
      end
      else if (hit(reg_addr, `BKRL_OFS_AL))
      begin
        r_d.rdata = r_q.addr_lo;
      end
      else if (hit(reg_addr, `BKRL_OFS_WS))
      begin
        r_d.rdata[`BKRL_BIT_WAKE] = r_q.wake;
      end
      else if (hit(reg_addr, `BKRL_OFS_FC))
      begin
        r_d.rdata[`BKRL_BIT_CFE] = r_q.cfe;
      end
      else if (hit(reg_addr, `BKRL_OFS_IST))
      begin
        r_d.rdata = {5'h00, r_q.ist};
      end
      else if (hit(reg_addr, `BKRL_OFS_IEN))
      begin
        r_d.rdata = {5'h00, r_q.ien};
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      r_q.en <= 1'b0;
      r_q.act <= 1'b0;
      r_q.addr_hi <= `BKRL_RST_BYTE;
      r_q.addr_lo <= `BKRL_RST_BYTE;
      r_q.wake <= 1'b0;
      r_q.cfe <= 1'b0;
      r_q.ist <= `BKRL_RST_IRQ;
      r_q.ien <= `BKRL_RST_IRQ;
      r_q.st <= bkrl_pkg::BKRL_ST_IDLE;
      r_q.brk <= 1'b0;
      r_q.irq <= 1'b0;
      r_q.rdata <= `BKRL_RST_BYTE;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = r_q.rdata;
  assign break_req = r_q.brk;
  assign irq = r_q.irq;

  // Checks of the break logic, all on the one clock
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Match on an instruction's last cycle breaks at once
  property p_match_brk;
    match && cpu_instr_last |=> break_req;
  endproperty
  a_match_brk: assert property (p_match_brk) else $error("Match missed break");

  // No match break while disabled
  property p_no_en;
    !r_q.en && !sw_trig && r_q.st == bkrl_pkg::BKRL_ST_IDLE |=> !break_req;
  endproperty
  a_no_en: assert property (p_no_en) else $error("Break while disabled");

  // Match leaves the active flag set
  property p_act_set;
    match |=> r_q.act;
  endproperty
  a_act_set: assert property (p_act_set) else $error("Active flag not set");

  // Soft trigger breaks and sets the active flag
  property p_sw_brk;
    sw_trig |=> break_req && r_q.act;
  endproperty
  a_sw_brk: assert property (p_sw_brk) else $error("Soft break missing");

  // A standing pulse ends unless a fresh trigger arrives
  property p_pulse;
    break_req && r_q.st == bkrl_pkg::BKRL_ST_IDLE && !sw_trig
      && !(match && cpu_instr_last) |=> !break_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Break not a pulse");

  // Pending match waits for the instruction end
  property p_wait_end;
    r_q.st == bkrl_pkg::BKRL_ST_PEND && !cpu_instr_last && !sw_trig |=> !break_req;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("Break before instruction end");

  // Pending state holds until the last cycle
  property p_pend_hold;
    r_q.st == bkrl_pkg::BKRL_ST_PEND && !cpu_instr_last |=> r_q.st == bkrl_pkg::BKRL_ST_PEND;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("Pending match lost");

  // Break out of low power sets the wake flag
  property p_wake;
    fire && cpu_low_power |=> r_q.wake ##1 (r_q.wake || $past(reg_wr));
  endproperty
  a_wake: assert property (p_wake) else $error("Wake flag not set");

  // Wake flag survives a blocked clear
  property p_protect;
    reg_wr && cpu_in_break && !r_q.cfe && r_q.wake |=> r_q.wake;
  endproperty
  a_protect: assert property (p_protect) else $error("Protected flag cleared");

  // Active flag survives a blocked clear
  property p_act_keep;
    reg_wr && cpu_in_break && !r_q.cfe && r_q.act |=> r_q.act;
  endproperty
  a_act_keep: assert property (p_act_keep) else $error("Protected active flag cleared");

  // Clear of the active flag works in break when allowed
  property p_act_clr;
    reg_wr && reg_addr == `BKRL_OFS_SC && !reg_wdata[`BKRL_BIT_ACT]
      && cpu_in_break && r_q.cfe && !match |=> !r_q.act;
  endproperty
  a_act_clr: assert property (p_act_clr) else $error("Allowed clear ignored");

  // Writing zero to the enable bit clears it
  property p_en_clr;
    reg_wr && reg_addr == `BKRL_OFS_SC && !reg_wdata[`BKRL_BIT_EN] |=> !r_q.en;
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("Enable not cleared");

  // Writing zero to the wake flag clears it outside break
  property p_wake_clr;
    reg_wr && reg_addr == `BKRL_OFS_WS && !reg_wdata[`BKRL_BIT_WAKE]
      && !cpu_in_break && !(fire && cpu_low_power) |=> !r_q.wake;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("Wake flag not cleared");

  // Address bytes are zero just after reset
  property p_rst_addr;
    $past(rst) |-> r_q.addr_hi == `BKRL_RST_BYTE && r_q.addr_lo == `BKRL_RST_BYTE;
  endproperty
  a_rst_addr: assert property (p_rst_addr) else $error("Address not cleared by reset");

  // High byte reads back as stored
  property p_addr_rd;
    reg_rd && reg_addr == `BKRL_OFS_AH |=> reg_rdata == $past(r_q.addr_hi);
  endproperty
  a_addr_rd: assert property (p_addr_rd) else $error("High byte readback wrong");

endmodule
`default_nettype wire

// ===== bench/bkrl_cpu_model.sv
// Purpose: Behavioural CPU core facing the break logic
// Assumes: Same clock; bench picks the fetch address
// Notes: Slow mode makes every instruction three cycles
`timescale 1ns/1ps
`default_nettype none
module bkrl_cpu_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] fetch,
  input wire logic slow,
  input wire logic sleep,
  input wire logic rti,
  input wire logic break_req,
  output logic [15:0] cpu_addr,
  output logic cpu_addr_valid,
  output logic cpu_instr_last,
  output logic cpu_in_break,
  output logic cpu_low_power
);
  logic [1:0] step_q; // Cycle within instruction
  assign cpu_addr = fetch;
  assign cpu_addr_valid = ~rst;
  assign cpu_instr_last = ~slow | (step_q == 2'h2);
  // Pacing, break state, and wake on break
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      step_q <= 2'h0;
      cpu_in_break <= 1'b0;
      cpu_low_power <= 1'b0;
    end
    else
    begin
      step_q <= (step_q == 2'h2) ? 2'h0 : step_q + 2'h1;
      cpu_in_break <= break_req | (cpu_in_break & ~rti);
      cpu_low_power <= ~break_req & (sleep | cpu_low_power);
    end
  end
endmodule
`default_nettype wire

// ===== bench/breakpoint_register_logic_tb.sv
// Purpose: Self-checking bench for the break logic
// Assumes: Read data stands the cycle after the strobe
// Notes: Break address drawn at random, fixed seed
`timescale 1ns/1ps
`default_nettype none
module breakpoint_register_logic_tb;
  logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, slow = 0, sleep = 0, rti = 0;
  logic [2:0] reg_addr = 3'h0; // Register index
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [15:0] fetch = 16'h0000, a, cpu_addr;
  logic cpu_addr_valid, cpu_instr_last, cpu_in_break, cpu_low_power, break_req, irq;
  logic [7:0] m [5] = '{8'hc0, 8'hff, 8'hff, 8'h02, 8'h80}; // Defined bits
  int num_errors = 0, compares = 0, cyc = 0, seed;
  always #5 clock = ~clock;
  bkrl_top uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid), .cpu_instr_last(cpu_instr_last), .cpu_in_break(cpu_in_break),
    .cpu_low_power(cpu_low_power), .break_req(break_req), .irq(irq));
  bkrl_cpu_model cpu (.clock(clock), .rst(rst), .fetch(fetch), .slow(slow), .sleep(sleep),
    .rti(rti), .break_req(break_req), .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid),
    .cpu_instr_last(cpu_instr_last), .cpu_in_break(cpu_in_break), .cpu_low_power(cpu_low_power));
  // Expected status/control value
  function automatic logic [7:0] sc(input logic en, input logic act);
    return {en, act, 6'h00};
  endfunction
  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] x, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= x;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] x, input logic [7:0] k, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= x;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg", e, reg_rdata & k);
  endtask
  // Present an address for one cycle
  task automatic hit(input logic [15:0] x);
    @(posedge clock);
    fetch <= x;
    @(posedge clock);
    fetch <= ~a;
  endtask
  // Count break pulses over n cycles
  task automatic brk(input int n, input logic [7:0] e);
    logic [7:0] c;
    // First look falls in the cycle right after the trigger edge
    #1 c = {7'h00, break_req === 1'b1};
    repeat (n - 1) @(posedge clock) #1 c += {7'h00, break_req === 1'b1};
    chk("break", e, c);
  endtask
  task automatic pulse_rti;
    @(posedge clock);
    rti <= 1'b1;
    @(posedge clock);
    rti <= 1'b0;
  endtask
  initial
  begin
    seed = $urandom(32'h2c44);
    a = 16'($urandom);
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    fetch <= ~a;
    for (int i = 0; i < 5; i++)
      rdchk(3'(i), m[i], 8'h00);
    wr(3'h1, a[15:8]);
    wr(3'h2, a[7:0]);
    rdchk(3'h1, 8'hff, a[15:8]);
    rdchk(3'h2, 8'hff, a[7:0]);
    hit(a);
    brk(4, 8'h00);
    wr(3'h0, 8'h80);
    hit(a);
    brk(4, 8'h01);
    rdchk(3'h0, 8'hc0, sc(1'b1, 1'b1));
    wr(3'h0, 8'h80);
    rdchk(3'h0, 8'hc0, sc(1'b1, 1'b1));
    wr(3'h4, 8'h80);
    wr(3'h0, 8'h80);
    rdchk(3'h0, 8'hc0, sc(1'b1, 1'b0));
    pulse_rti();
    wr(3'h4, 8'h00);
    hit(a ^ 16'h0100);
    hit(a ^ 16'h0001);
    brk(4, 8'h00);
    @(posedge clock);
    slow <= 1'b1;
    hit(a);
    brk(6, 8'h01);
    pulse_rti();
    @(posedge clock);
    sleep <= 1'b1;
    @(posedge clock);
    sleep <= 1'b0;
    wr(3'h0, 8'hc0);
    brk(4, 8'h01);
    rdchk(3'h3, 8'h02, 8'h02);
    pulse_rti();
    wr(3'h3, 8'h00);
    rdchk(3'h3, 8'h02, 8'h00);
    // Software goes back to wait after the wake break
    @(posedge clock);
    sleep <= 1'b1;
    @(posedge clock);
    sleep <= 1'b0;
    wr(3'h7, 8'h07);
    #1 chk("irq", 8'h01, {7'h00, irq});
    wr(3'h6, 8'h07);
    #1 chk("irq", 8'h00, {7'h00, irq});
    wr(3'h7, 8'h00);
    wr(3'h0, 8'hc0);
    brk(3, 8'h01);
    chk("irq", 8'h00, {7'h00, irq});
    rdchk(3'h5, 8'h07, 8'h06);
    rdchk(3'h6, 8'hff, 8'h00);
    rdchk(3'h3, 8'h02, 8'h02);
    wr(3'h0, 8'h00);
    rdchk(3'h0, 8'hc0, sc(1'b0, 1'b1));
    hit(a);
    brk(4, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
